// ---- include/ldc_defs.vh ----
// register indices, field positions, reset values and limits of the latch delay correction block
`ifndef LDC_DEFS_VH
`define LDC_DEFS_VH

// register indices; byte address on the bus is four times the index
`define LDC_IDX_CORR_ONE 16'h3709
`define LDC_IDX_SETUP_THREE 16'h3724
`define LDC_IDX_CORR_TWO 16'h3792
`define LDC_IDX_P1_RISE 16'h0000
`define LDC_IDX_P1_FALL 16'h0001
`define LDC_IDX_P2_RISE 16'h0002
`define LDC_IDX_P2_FALL 16'h0003
`define LDC_IDX_STATUS 16'h0004

// correction-select bit in the extended setup word
`define LDC_SEL_BIT 5

// accepted correction range, in 25 ns steps (-2000 .. 2000)
`define LDC_CORR_MIN 16'hF830
`define LDC_CORR_MAX 16'h07D0

// reset values
`define LDC_CORR_RESET 16'h0000
`define LDC_SETUP_RESET 16'h0000

// speed input is position change per 25 ns step, 8 fraction bits
`define LDC_VEL_FRAC 8

`endif

// ---- hdl/ldc_edge_capture.v ----
// edge detection and corrected position capture for one touch-probe input
`timescale 1ns/1ps
`include "ldc_defs.vh"

module ldc_edge_capture (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // probe and motion inputs
  input wire probeIn,
  input wire [31:0] motorPos,
  input wire [15:0] motorVel,
  // selected corrections
  input wire [15:0] riseCorr,
  input wire [15:0] fallCorr,
  // captured values and one-cycle event pulses
  output reg [31:0] posRise_q,
  output reg [31:0] posFall_q,
  output reg riseSeen_q,
  output reg fallSeen_q
);

  reg probe_q;
  wire riseEdge;
  wire fallEdge;

  // back-dates a position by speed times correction steps
  function [31:0] compensate;
    input [31:0] pos;
    input [15:0] vel;
    input [15:0] corr;
    reg signed [31:0] prod;
    reg signed [31:0] backOff;
    begin
      prod = $signed(vel) * $signed(corr);
      // shift on its own: next to the unsigned position it would turn
      // logical and lose the sign of a negative product
      backOff = prod >>> `LDC_VEL_FRAC;
      compensate = pos - backOff;
    end
  endfunction

  // coupler on is a rising edge, coupler off a falling edge
  assign riseEdge = probeIn & ~probe_q;
  assign fallEdge = ~probeIn & probe_q;

  // each edge latches a corrected position; value holds until the next edge
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      probe_q <= 1'b0;
      posRise_q <= 32'h00000000;
      posFall_q <= 32'h00000000;
      riseSeen_q <= 1'b0;
      fallSeen_q <= 1'b0;
    end
    else
    begin
      probe_q <= probeIn;
      riseSeen_q <= riseEdge;
      fallSeen_q <= fallEdge;
      if (riseEdge)
        posRise_q <= compensate(motorPos, motorVel, riseCorr);
      if (fallEdge)
        posFall_q <= compensate(motorPos, motorVel, fallCorr);
    end
  end

endmodule

// ---- hdl/ldc_latch_delay_correction.v ----
// latch delay correction block: apb registers and two touch-probe captures
`timescale 1ns/1ps
`include "ldc_defs.vh"

module ldc_latch_delay_correction (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // touch-probe inputs, high while the coupler conducts
  input wire [1:0] probeIn,
  // motion inputs
  input wire [31:0] motorPos,
  input wire [15:0] motorVel
);

  reg [15:0] corrOne_q;
  reg [15:0] corrTwo_q;
  reg [15:0] setupThree_q;
  reg [3:0] capFlags_q;
  reg [3:0] capFlags_d;
  reg [31:0] rdData_d;
  reg rdErr_d;
  reg wrErr_d;
  wire [15:0] regIdx;
  wire aligned;
  wire accessPhase;
  wire wrTake;
  wire selSplit;
  wire [15:0] fallCorr;
  wire [31:0] p1Rise;
  wire [31:0] p1Fall;
  wire [31:0] p2Rise;
  wire [31:0] p2Fall;
  wire [3:0] capEvents;
  wire hitCorrOne;
  wire hitCorrTwo;
  wire hitSetup;
  wire hitP1Rise;
  wire hitP1Fall;
  wire hitP2Rise;
  wire hitP2Fall;
  wire hitStatus;

  // true when a 16-bit value lies inside the accepted correction range
  function inRange;
    input [15:0] val;
    begin
      inRange = ($signed(val) >= $signed(`LDC_CORR_MIN)) &&
        ($signed(val) <= $signed(`LDC_CORR_MAX));
    end
  endfunction

  // true when the bus address selects the given register index
  function hit;
    input [15:0] cur;
    input ok;
    input [15:0] idx;
    begin
      hit = ok && (cur == idx);
    end
  endfunction

  // address decode: word index plus alignment
  assign regIdx = paddr[17:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign accessPhase = psel & penable;
  // writes land only on the edge where pready is seen high
  assign wrTake = accessPhase & pready & pwrite;
  // decoded selects; address goes in as an argument so every change of it
  // re-evaluates the decode, which a hidden read inside the function misses
  assign hitCorrOne = hit(regIdx, aligned, `LDC_IDX_CORR_ONE);
  assign hitCorrTwo = hit(regIdx, aligned, `LDC_IDX_CORR_TWO);
  assign hitSetup = hit(regIdx, aligned, `LDC_IDX_SETUP_THREE);
  assign hitP1Rise = hit(regIdx, aligned, `LDC_IDX_P1_RISE);
  assign hitP1Fall = hit(regIdx, aligned, `LDC_IDX_P1_FALL);
  assign hitP2Rise = hit(regIdx, aligned, `LDC_IDX_P2_RISE);
  assign hitP2Fall = hit(regIdx, aligned, `LDC_IDX_P2_FALL);
  assign hitStatus = hit(regIdx, aligned, `LDC_IDX_STATUS);

  // edge correction selection
  assign selSplit = setupThree_q[`LDC_SEL_BIT];
  // select clear reuses the first value, second one is ignored
  assign fallCorr = selSplit ? corrTwo_q : corrOne_q;

  // probe 1 capture; rising edges always take the first value
  ldc_edge_capture probeOne (
    .sys_clk(sys_clk),
    .rst(rst),
    .probeIn(probeIn[0]),
    .motorPos(motorPos),
    .motorVel(motorVel),
    .riseCorr(corrOne_q),
    .fallCorr(fallCorr),
    .posRise_q(p1Rise),
    .posFall_q(p1Fall),
    .riseSeen_q(capEvents[0]),
    .fallSeen_q(capEvents[1])
  );

  // probe 2 capture, same correction choice
  ldc_edge_capture probeTwo (
    .sys_clk(sys_clk),
    .rst(rst),
    .probeIn(probeIn[1]),
    .motorPos(motorPos),
    .motorVel(motorVel),
    .riseCorr(corrOne_q),
    .fallCorr(fallCorr),
    .posRise_q(p2Rise),
    .posFall_q(p2Fall),
    .riseSeen_q(capEvents[2]),
    .fallSeen_q(capEvents[3])
  );

  // capture flags: a new capture wins over a write-one-to-clear
  always @*
  begin
    capFlags_d = capFlags_q;
    if (wrTake && hitStatus)
      capFlags_d = capFlags_d & ~pwdata[3:0];
    capFlags_d = capFlags_d | capEvents;
  end

  // read mux and error decode; unmapped or misaligned answers with pslverr
  always @*
  begin
    rdData_d = 32'h00000000;
    rdErr_d = 1'b0;
    wrErr_d = 1'b0;
    if (hitCorrOne)
    begin
      rdData_d = {{16{corrOne_q[15]}}, corrOne_q};
      wrErr_d = ~inRange(pwdata[15:0]);
    end
    else if (hitCorrTwo)
    begin
      rdData_d = {{16{corrTwo_q[15]}}, corrTwo_q};
      wrErr_d = ~inRange(pwdata[15:0]);
    end
    else if (hitSetup)
      rdData_d = {16'h0000, setupThree_q};
    else if (hitP1Rise)
    begin
      rdData_d = p1Rise;
      wrErr_d = 1'b1;
    end
    else if (hitP1Fall)
    begin
      rdData_d = p1Fall;
      wrErr_d = 1'b1;
    end
    else if (hitP2Rise)
    begin
      rdData_d = p2Rise;
      wrErr_d = 1'b1;
    end
    else if (hitP2Fall)
    begin
      rdData_d = p2Fall;
      wrErr_d = 1'b1;
    end
    else if (hitStatus)
      rdData_d = {28'h0000000, capFlags_q};
    else
    begin
      rdErr_d = 1'b1;
      wrErr_d = 1'b1;
    end
  end

  // apb answer: one wait state so every output comes from a flop
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= accessPhase & ~pready;
      prdata <= (accessPhase & ~pready & ~pwrite) ? rdData_d : 32'h00000000;
      pslverr <= accessPhase & ~pready & (pwrite ? wrErr_d : rdErr_d);
    end
  end

  // configuration registers; out-of-range corrections are refused whole
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      corrOne_q <= `LDC_CORR_RESET;
      corrTwo_q <= `LDC_CORR_RESET;
      setupThree_q <= `LDC_SETUP_RESET;
      capFlags_q <= 4'h0;
    end
    else
    begin
      capFlags_q <= capFlags_d;
      if (wrTake && hitCorrOne && inRange(pwdata[15:0]))
        corrOne_q <= pwdata[15:0];
      if (wrTake && hitCorrTwo && inRange(pwdata[15:0]))
        corrTwo_q <= pwdata[15:0];
      if (wrTake && hitSetup)
        setupThree_q <= pwdata[15:0];
    end
  end

endmodule

// ---- tb/ldc_latch_delay_correction_assertions.sv ----
// apb side checks of the latch delay correction block
`timescale 1ns/1ps
module ldc_checker (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // every access is answered after exactly one wait state
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("data outside access");
  a_corr_range: assert property (pready && !pwrite && paddr == 18'h0DC24
    |-> $signed(prdata) >= -2000 && $signed(prdata) <= 2000)
    else $error("correction out of range");
  a_setup_upper: assert property (pready && paddr == 18'h0DC90
    |-> prdata[31:16] == 16'h0) else $error("setup upper bits");
  a_range_err: assert property (pready && pwrite && paddr == 18'h0DC24
    && $signed(pwdata[15:0]) > 2000 |-> pslverr) else $error("range kept");
  a_cap_ro: assert property (pready && pwrite && paddr <= 18'h0000C
    |-> pslverr) else $error("capture writable");
  a_hole_err: assert property (pready && paddr == 18'h00014
    |-> pslverr && prdata == 32'h0) else $error("hole answered");
  cover property (pready && pwrite && !pslverr);
  cover property (pready && pslverr);
  cover property (pready && !pwrite && prdata != 32'h0);
endmodule

// ---- tb/ldc_probe_sensor.sv ----
// trigger sensor model driving two photocoupler latch inputs
`timescale 1ns/1ps
module ldc_probe_sensor (
  // clock
  input wire sys_clk,
  // trigger levels and coupler lag in cycles
  input wire [1:0] trigReq,
  input wire [2:0] delay,
  // coupler outputs, high while conducting
  output logic [1:0] probeIn
);
  logic [15:0] hist = 16'h0;
  initial probeIn = 2'h0;
  // a slow coupler models aging; the lag is what the correction hides
  always @(posedge sys_clk)
  begin
    hist <= {hist[13:0], trigReq};
    probeIn <= delay == 3'h0 ? trigReq : hist[2 * delay - 1 -: 2];
  end
endmodule

// ---- tb/test_ldc_latch_delay_correction.sv ----
// self-checking bench of the latch delay correction block
`timescale 1ns/1ps
module test_ldc_latch_delay_correction;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, er;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, motorPos = 32'h0, rd, seed = 32'hBAC6;
  logic [15:0] motorVel = 16'h0;
  logic [1:0] probeIn, trigReq = 2'h0;
  logic [2:0] delay = 3'h0;
  logic pslverr;
  int fails = 0, compares = 0, c1, c2, cs;
  longint ex;
  ldc_latch_delay_correction i_ldc_latch_delay_correction (.sys_clk(sys_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .probeIn(probeIn), .motorPos(motorPos),
    .motorVel(motorVel));
  ldc_probe_sensor i_ldc_probe_sensor (.sys_clk(sys_clk), .trigReq(trigReq),
    .delay(delay), .probeIn(probeIn));
  initial forever #10 sys_clk = ~sys_clk;
  function automatic [31:0] lfsr(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input [31:0] ex, input [31:0] got);
    compares++;
    if (got !== ex)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one apb transfer; request held until pready is sampled
  task automatic apb(input wr, input [17:0] a, input [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (n == 20) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input string nm, input [17:0] a, input [31:0] ex);
    apb(1'h0, a, 32'h0);
    chk(nm, ex, rd);
  endtask
  task automatic wchk(input string nm, input [17:0] a, input [31:0] d,
    input e);
    apb(1'h1, a, d);
    chk(nm, {31'h0, e}, {31'h0, er});
  endtask
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    rchk("c1", 18'h0DC24, 32'h0);
    rchk("setup", 18'h0DC90, 32'h0);
    rchk("c2", 18'h0DE48, 32'h0);
    rchk("hole", 18'h00014, 32'h0);
    chk("hole err", 32'h1, {31'h0, er});
    rchk("misalign", 18'h0DC26, 32'h0);
    chk("misalign err", 32'h1, {31'h0, er});
    wchk("cap wr", 18'h00000, 32'h0, 1'h1);
    wchk("c1 max", 18'h0DC24, 32'h7D0, 1'h0);
    wchk("c1 over", 18'h0DC24, 32'h7D1, 1'h1);
    wchk("c1 under", 18'h0DC24, 32'hFFFFF82F, 1'h1);
    rchk("c1 kept", 18'h0DC24, 32'h7D0);
    wchk("c2 min", 18'h0DE48, 32'hFFFFF830, 1'h0);
    rchk("c2 back", 18'h0DE48, 32'hFFFFF830);
    $display("registers done");
    // both select settings, every probe and edge, random lag and motion
    for (int sel = 0; sel < 2; sel++)
    begin
      seed = lfsr(seed);
      c1 = int'(seed % 4001) - 2000;
      seed = lfsr(seed);
      c2 = int'(seed % 4001) - 2000;
      wchk("setup", 18'h0DC90, sel << 5, 1'h0);
      wchk("c1", 18'h0DC24, c1, 1'h0);
      wchk("c2", 18'h0DE48, c2, 1'h0);
      for (int k = 0; k < 4; k++)
      begin
        seed = lfsr(seed);
        motorPos <= seed;
        motorVel <= seed[27:12];
        delay <= seed[2:0];
        trigReq[k / 2] <= ~k[0];
        repeat (12) @(posedge sys_clk);
        cs = (k % 2 == 0 || sel == 0) ? c1 : c2;
        ex = $signed(motorPos) - ((longint'($signed(motorVel)) * cs) >>> 8);
        rchk("capture", 18'(k * 4), ex[31:0]);
      end
      rchk("status", 18'h00010, 32'hF);
      wchk("clear", 18'h00010, 32'hF, 1'h0);
      rchk("cleared", 18'h00010, 32'h0);
      $display("capture select %0d done", sel);
    end
    conclude;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    conclude;
  end
endmodule
bind ldc_latch_delay_correction ldc_checker i_chk (.sys_clk(sys_clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
